//--- core/tx_cmd_if.sv
`timescale 1ns/1ns
// DWORD write stream from the host into the transmit data FIFO
interface tx_cmd_if;
  logic        wr_valid;
  logic        wr_ready;
  logic [31:0] wr_data;

  modport host (
    output wr_valid,
    output wr_data,
    input  wr_ready
  );

  modport dev (
    input  wr_valid,
    input  wr_data,
    output wr_ready
  );
endinterface

//--- core/tx_cmd_parser.sv
`timescale 1ns/1ns
module tx_cmd_parser
  import tx_cmd_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      rstn,
  tx_cmd_if.dev                          link,
  output logic [tx_cmd_pkg::DWORD_W-1:0] pay_data,
  output logic [3:0]                     pay_be,
  output logic                           pay_last,
  output logic                           pay_valid,
  input  wire logic                      pay_ready,
  output logic                           buffer_loaded_flag,
  output logic                           transmit_error_flag,
  input  wire logic                      err_clear,
  output logic                           sts_valid,
  output logic [tx_cmd_pkg::TAG_W-1:0]   sts_tag,
  output logic                           sts_err,
  output logic [tx_cmd_pkg::WCNT_W-1:0]  stored_dwords
);
  import tx_cmd_pkg::*;

  typedef enum logic [1:0] {
    S_CMD_A = 2'h0,
    S_CMD_B = 2'h1,
    S_DATA  = 2'h3
  } state_t;

  typedef struct packed {
    logic [DWORD_W-1:0] data;
    logic [3:0]         be;
    logic               last;
  } entry_t;

  typedef struct packed {
    state_t             st;
    logic [DWORD_W-1:0] cmd_a;
    logic [WCNT_W-1:0]  idx;
    logic [WCNT_W-1:0]  ndata;
    logic [WCNT_W-1:0]  ntot;
    logic [DWORD_W-1:0] first_b;
    logic               open;
    logic [SUM_W-1:0]   sum;
    logic               pkt_err;
    logic               err;
    logic               done;
    logic               sts_valid;
    logic [TAG_W-1:0]   sts_tag;
    logic               sts_err;
    logic [WCNT_W-1:0]  stored;
    logic               ready;
    logic [1:0]         vld;
    entry_t [1:0]       ent;
  } regs_t;

  localparam regs_t REGS_RST = '{
    st:        S_CMD_A,
    cmd_a:     DWORD_RST,
    idx:       WCNT_RST,
    ndata:     WCNT_RST,
    ntot:      WCNT_RST,
    first_b:   DWORD_RST,
    open:      1'b0,
    sum:       SUM_RST,
    pkt_err:   1'b0,
    err:       1'b0,
    done:      1'b0,
    sts_valid: 1'b0,
    sts_tag:   TAG_RST,
    sts_err:   1'b0,
    stored:    WCNT_RST,
    ready:     1'b1,
    vld:       2'h0,
    ent:       '0
  };

  regs_t s_q;
  regs_t s_d;

  // Byte lanes valid in the payload word at position idx of the buffer
  function automatic logic [3:0] lanes(input logic [31:0] a, input logic [WCNT_W-1:0] idx,
                                       input logic [WCNT_W-1:0] nd);
    logic [3:0]       m;
    logic [SUM_W-1:0] endb;
    m = 4'hf;
    endb = SUM_W'(a[A_OFF_HI:A_OFF_LO]) + SUM_W'(a[A_SIZE_HI:A_SIZE_LO]);
    if (idx == WCNT_W'(a[A_OFF_HI:A_OFF_LO+2]))
    begin
      m = m & (4'hf << a[A_OFF_LO+1:A_OFF_LO]);
    end
    if ((idx == nd - 10'h001) && (endb[1:0] != 2'h0))
    begin
      m = m & (4'hf >> (3'h4 - {1'b0, endb[1:0]}));
    end
    return m;
  endfunction

  logic               take;
  logic               pop;
  logic               push;
  entry_t             pe;
  logic               fs;
  logic               ls;
  logic               bad_b;
  logic [SUM_W-1:0]   new_sum;
  logic [WCNT_W-1:0]  skip;
  logic [3:0]         be;

  always_comb
  begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.sts_valid = 1'b0;
    take = link.wr_valid && s_q.ready;
    pop = s_q.vld[0] && pay_ready;
    push = 1'b0;
    pe = '0;
    fs = s_q.cmd_a[A_FIRST];
    ls = s_q.cmd_a[A_LAST];
    bad_b = 1'b0;
    new_sum = SUM_RST;
    skip = WCNT_W'(s_q.cmd_a[A_OFF_HI:A_OFF_LO+2]);
    be = lanes(s_q.cmd_a, s_q.idx, s_q.ndata);

    // A clear in the same cycle as a new error loses to the error
    if (err_clear)
    begin
      s_d.err = 1'b0;
    end

    if (take)
    begin
      unique case (s_q.st)
        S_CMD_A:
        begin
          s_d.cmd_a = link.wr_data & A_KEEP_MASK;
          s_d.st = S_CMD_B;
        end
        S_CMD_B:
        begin
          // A first segment inside an open packet, or a continuation with no
          // packet open, is treated like a command B mismatch
          bad_b = fs ? s_q.open : (!s_q.open || (link.wr_data != s_q.first_b));
          new_sum = fs ? SUM_W'(s_q.cmd_a[A_SIZE_HI:A_SIZE_LO])
                       : s_q.sum + SUM_W'(s_q.cmd_a[A_SIZE_HI:A_SIZE_LO]);
          if (fs)
          begin
            s_d.first_b = link.wr_data;
            s_d.stored = WCNT_RST;
          end
          s_d.sum = new_sum;
          s_d.pkt_err = (fs ? 1'b0 : s_q.pkt_err) | bad_b;
          if (ls && (new_sum != SUM_W'(link.wr_data[B_LEN_HI:B_LEN_LO])))
          begin
            s_d.pkt_err = 1'b1;
          end
          s_d.err = s_d.err | s_d.pkt_err;
          s_d.open = !ls;
          if (ls)
          begin
            s_d.sts_valid = 1'b1;
            s_d.sts_tag = link.wr_data[B_TAG_HI:B_TAG_LO];
            s_d.sts_err = s_d.pkt_err;
          end
          s_d.ndata = data_words(s_q.cmd_a);
          s_d.ntot = total_words(s_q.cmd_a);
          s_d.idx = WCNT_RST;
          if (total_words(s_q.cmd_a) == WCNT_RST)
          begin
            s_d.st = S_CMD_A;
            s_d.done = s_q.cmd_a[A_IOC];
          end
          else
          begin
            s_d.st = S_DATA;
          end
        end
        S_DATA:
        begin
          // Offset words and padding words fall through without a slot
          if ((s_q.idx >= skip) && (s_q.idx < s_q.ndata) && (be != 4'h0))
          begin
            push = 1'b1;
            pe.data = link.wr_data;
            pe.be = be;
            pe.last = ls && (s_q.idx == s_q.ndata - 10'h001);
            s_d.stored = s_q.stored + 10'h001;
          end
          s_d.idx = s_q.idx + 10'h001;
          if (s_q.idx == s_q.ntot - 10'h001)
          begin
            s_d.st = S_CMD_A;
            s_d.done = s_q.cmd_a[A_IOC];
          end
        end
        default:
        begin
          s_d.st = S_CMD_A;
        end
      endcase
    end

    if (pop)
    begin
      s_d.ent[0] = s_q.ent[1];
      s_d.vld = {1'b0, s_q.vld[1]};
    end
    if (push)
    begin
      if (!s_d.vld[0])
      begin
        s_d.ent[0] = pe;
        s_d.vld[0] = 1'b1;
      end
      else
      begin
        s_d.ent[1] = pe;
        s_d.vld[1] = 1'b1;
      end
    end
    // Registered ready costs a bubble when full but keeps the port a flop
    s_d.ready = !s_d.vld[1];
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q <= REGS_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign link.wr_ready       = s_q.ready;
  assign pay_data            = s_q.ent[0].data;
  assign pay_be              = s_q.ent[0].be;
  assign pay_last            = s_q.ent[0].last;
  assign pay_valid           = s_q.vld[0];
  assign buffer_loaded_flag  = s_q.done;
  assign transmit_error_flag = s_q.err;
  assign sts_valid           = s_q.sts_valid;
  assign sts_tag             = s_q.sts_tag;
  assign sts_err             = s_q.sts_err;
  assign stored_dwords       = s_q.stored;

endmodule // tx_cmd_parser

//--- core/tx_cmd_pkg.sv
package tx_cmd_pkg;

  localparam int unsigned DWORD_W  = 32;
  localparam int unsigned TAG_W    = 16;
  localparam int unsigned SIZE_W   = 11;
  localparam int unsigned WCNT_W   = 10;
  localparam int unsigned SUM_W    = 12;

  // Command A field positions
  localparam int unsigned A_IOC      = 31;
  localparam int unsigned A_ALIGN_HI = 25;
  localparam int unsigned A_ALIGN_LO = 24;
  localparam int unsigned A_OFF_HI   = 20;
  localparam int unsigned A_OFF_LO   = 16;
  localparam int unsigned A_FIRST    = 13;
  localparam int unsigned A_LAST     = 12;
  localparam int unsigned A_SIZE_HI  = 10;
  localparam int unsigned A_SIZE_LO  = 0;

  // Bits of command A that carry meaning; everything else is reserved
  localparam logic [31:0] A_KEEP_MASK = 32'h831f_37ff;

  // Command B field positions
  localparam int unsigned B_TAG_HI = 31;
  localparam int unsigned B_TAG_LO = 16;
  localparam int unsigned B_LEN_HI = 10;
  localparam int unsigned B_LEN_LO = 0;

  // End alignment codes
  localparam logic [1:0] ALIGN_4  = 2'h0;
  localparam logic [1:0] ALIGN_16 = 2'h1;
  localparam logic [1:0] ALIGN_32 = 2'h2;

  // Alignment granules in DWORDs
  localparam logic [WCNT_W-1:0] GRAN_1 = 10'h001;
  localparam logic [WCNT_W-1:0] GRAN_4 = 10'h004;
  localparam logic [WCNT_W-1:0] GRAN_8 = 10'h008;

  // Reset values
  localparam logic [DWORD_W-1:0] DWORD_RST = 32'h0000_0000;
  localparam logic [WCNT_W-1:0]  WCNT_RST  = 10'h000;
  localparam logic [SUM_W-1:0]   SUM_RST   = 12'h000;
  localparam logic [TAG_W-1:0]   TAG_RST   = 16'h0000;

  // DWORDs from buffer start to the end of the payload, offset included
  function automatic logic [WCNT_W-1:0] data_words(input logic [31:0] a);
    logic [SUM_W-1:0] bytes;
    bytes = SUM_W'(a[A_OFF_HI:A_OFF_LO]) + SUM_W'(a[A_SIZE_HI:A_SIZE_LO]) + 12'h003;
    return bytes[SUM_W-1:2];
  endfunction

  // DWORDs including end padding up to the selected alignment
  function automatic logic [WCNT_W-1:0] total_words(input logic [31:0] a);
    logic [WCNT_W-1:0] g;
    logic [WCNT_W-1:0] d;
    d = data_words(a);
    unique case (a[A_ALIGN_HI:A_ALIGN_LO])
      ALIGN_16: g = GRAN_4;
      ALIGN_32: g = GRAN_8;
      default:  g = GRAN_1;
    endcase
    return (d + g - 10'h001) & ~(g - 10'h001);
  endfunction

endpackage

//--- core/tx_cmd_writer.sv
`timescale 1ns/1ns
module tx_cmd_writer
  import tx_cmd_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      rstn,
  tx_cmd_if.host                         link,
  input  wire logic                      req_valid,
  output logic                           req_ready,
  input  wire logic [tx_cmd_pkg::DWORD_W-1:0] cmd_a,
  input  wire logic [tx_cmd_pkg::DWORD_W-1:0] cmd_b,
  input  wire logic                      data_valid,
  output logic                           data_ready,
  input  wire logic [tx_cmd_pkg::DWORD_W-1:0] data,
  output logic                           buf_sent
);
  import tx_cmd_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_A    = 3'h1,
    H_B    = 3'h3,
    H_DATA = 3'h2,
    H_PAD  = 3'h6
  } hstate_t;

  typedef struct packed {
    hstate_t            st;
    logic [DWORD_W-1:0] a;
    logic [DWORD_W-1:0] b;
    logic [WCNT_W-1:0]  idx;
    logic [WCNT_W-1:0]  nd;
    logic [WCNT_W-1:0]  nt;
    logic               wv;
    logic [DWORD_W-1:0] wd;
    logic               req_rdy;
    logic               dat_rdy;
    logic               sent;
  } hregs_t;

  localparam hregs_t HREGS_RST = '{
    st: H_IDLE, a: DWORD_RST, b: DWORD_RST, idx: WCNT_RST, nd: WCNT_RST, nt: WCNT_RST,
    wv: 1'b0, wd: DWORD_RST, req_rdy: 1'b0, dat_rdy: 1'b0, sent: 1'b0
  };

  hregs_t h_q;
  hregs_t h_d;

  always_comb
  begin
    h_d = h_q;
    h_d.sent = 1'b0;
    if (h_q.wv && link.wr_ready)
    begin
      h_d.wv = 1'b0;
      unique case (h_q.st)
        H_A:
        begin
          h_d.wd = h_q.b;
          h_d.wv = 1'b1;
          h_d.st = H_B;
        end
        H_B:
        begin
          h_d.idx = WCNT_RST;
          h_d.nd = data_words(h_q.a);
          h_d.nt = total_words(h_q.a);
          if (total_words(h_q.a) == WCNT_RST)
          begin
            h_d.st = H_IDLE;
            h_d.sent = 1'b1;
          end
          else
          begin
            h_d.st = (data_words(h_q.a) == WCNT_RST) ? H_PAD : H_DATA;
          end
        end
        default:
        begin
          h_d.idx = h_q.idx + 10'h001;
          if (h_q.idx + 10'h001 == h_q.nt)
          begin
            h_d.st = H_IDLE;
            h_d.sent = 1'b1;
          end
          else if (h_q.idx + 10'h001 >= h_q.nd)
          begin
            h_d.st = H_PAD;
          end
        end
      endcase
    end
    if (h_q.st == H_IDLE && req_valid && h_q.req_rdy)
    begin
      h_d.a = cmd_a & A_KEEP_MASK;
      h_d.b = cmd_b;
      h_d.wd = cmd_a & A_KEEP_MASK;
      h_d.wv = 1'b1;
      h_d.st = H_A;
    end
    if (h_q.st == H_DATA && data_valid && h_q.dat_rdy)
    begin
      h_d.wd = data;
      h_d.wv = 1'b1;
    end
    if (h_d.st == H_PAD && !h_d.wv)
    begin
      h_d.wd = DWORD_RST;
      h_d.wv = 1'b1;
    end
    // One payload word in flight at a time: half rate, but every port is a flop
    h_d.req_rdy = (h_d.st == H_IDLE) && !h_d.wv;
    h_d.dat_rdy = (h_d.st == H_DATA) && !h_d.wv;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      h_q <= HREGS_RST;
    end
    else
    begin
      h_q <= h_d;
    end
  end

  assign link.wr_valid = h_q.wv;
  assign link.wr_data  = h_q.wd;
  assign req_ready     = h_q.req_rdy;
  assign data_ready    = h_q.dat_rdy;
  assign buf_sent      = h_q.sent;

endmodule // tx_cmd_writer

//--- testbench/tx_cmd_parser_properties.sv
`timescale 1ns/1ns
module tx_cmd_parser_properties
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        wr_valid,
  input wire logic        wr_ready,
  input wire logic [31:0] wr_data,
  input wire logic        pay_valid,
  input wire logic        pay_ready,
  input wire logic [31:0] pay_data,
  input wire logic        buffer_loaded_flag,
  input wire logic        transmit_error_flag,
  input wire logic        err_clear,
  input wire logic        sts_valid,
  input wire logic [15:0] sts_tag
);
  logic        tk;
  logic [1:0]  ph_q;
  logic [31:0] a_q, b_q, b0_q;
  logic [9:0]  n_q, dw, g, tot;
  logic [11:0] sum_q, nsum;

  // Own word count per buffer, so the checker does not share the design's helpers
  always_comb
  begin
    tk   = wr_valid && wr_ready;
    dw   = 10'((12'(a_q[20:16]) + 12'(a_q[10:0]) + 12'h003) >> 2);
    g    = (a_q[25:24] == 2'h1) ? 10'h004 : (a_q[25:24] == 2'h2) ? 10'h008 : 10'h001;
    tot  = (dw + g - 10'h001) & ~(g - 10'h001);
    nsum = (a_q[13] ? 12'h000 : sum_q) + 12'(a_q[10:0]);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ph_q  <= 2'h0;
      a_q   <= 32'h0;
      b_q   <= 32'h0;
      b0_q  <= 32'h0;
      n_q   <= 10'h0;
      sum_q <= 12'h0;
    end
    else if (tk)
    begin
      if (ph_q == 2'h0)
      begin
        a_q  <= wr_data;
        ph_q <= 2'h1;
      end
      else if (ph_q == 2'h1)
      begin
        b_q   <= wr_data;
        b0_q  <= a_q[13] ? wr_data : b0_q;
        sum_q <= nsum;
        n_q   <= 10'h0;
        ph_q  <= (tot == 10'h0) ? 2'h0 : 2'h2;
      end
      else
      begin
        n_q  <= n_q + 10'h1;
        ph_q <= (n_q + 10'h1 == tot) ? 2'h0 : 2'h2;
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence b_taken;
    tk && ph_q == 2'h1;
  endsequence

  sequence ioc_end;
    tk && ph_q == 2'h2 && n_q + 10'h1 == tot && a_q[31];
  endsequence

  link_hold_a: assert property (
    wr_valid && !wr_ready |=> wr_valid && $stable(wr_data))
    else $error("link word changed while waiting");
  pay_hold_a: assert property (
    pay_valid && !pay_ready |=> pay_valid && $stable(pay_data))
    else $error("payload word changed while waiting");
  pad_zero_a: assert property (
    wr_valid && ph_q == 2'h2 && n_q >= dw |-> wr_data == 32'h0)
    else $error("padding word not zero");
  b_mismatch_a: assert property (
    b_taken ##0 (!a_q[13] && wr_data != b0_q) |-> ##[1:4] transmit_error_flag)
    else $error("command B mismatch not flagged");
  len_check_a: assert property (
    b_taken ##0 (a_q[12] && nsum != 12'(wr_data[10:0])) |-> ##[1:4] transmit_error_flag)
    else $error("length mismatch not flagged");
  ioc_flag_a: assert property (
    ioc_end |-> ##[1:8] buffer_loaded_flag)
    else $error("buffer loaded flag missing");
  status_tag_a: assert property (
    sts_valid |-> sts_tag == b_q[31:16])
    else $error("status tag differs from command B");
  err_sticky_a: assert property (
    transmit_error_flag && !err_clear |=> transmit_error_flag)
    else $error("error flag dropped without clear");
endmodule // tx_cmd_parser_properties

//--- testbench/tx_cmd_parser_tb.sv
`timescale 1ns/1ns
module tx_cmd_parser_tb;
  logic        clk, rstn, req_valid, req_ready, data_valid, data_ready, buf_sent;
  logic        pay_last, pay_valid, pay_ready, err_clear, sts_valid, sts_err;
  logic        buffer_loaded_flag, transmit_error_flag;
  logic [31:0] cmd_a, cmd_b, data, pay_data;
  logic [3:0]  pay_be;
  logic [15:0] sts_tag;
  logic [9:0]  stored_dwords;
  logic [36:0] exp_q[$], got_q[$];
  int          n_errors, num_checks, n_ioc, n_sts, cyc, k;

  tx_cmd_if link_if();

  tx_cmd_writer tx_cmd_writer_i (.clk(clk), .rstn(rstn), .link(link_if),
    .req_valid(req_valid), .req_ready(req_ready), .cmd_a(cmd_a), .cmd_b(cmd_b),
    .data_valid(data_valid), .data_ready(data_ready), .data(data), .buf_sent(buf_sent));

  tx_cmd_parser tx_cmd_parser_i (.clk(clk), .rstn(rstn), .link(link_if),
    .pay_data(pay_data), .pay_be(pay_be), .pay_last(pay_last), .pay_valid(pay_valid),
    .pay_ready(pay_ready), .buffer_loaded_flag(buffer_loaded_flag),
    .transmit_error_flag(transmit_error_flag), .err_clear(err_clear),
    .sts_valid(sts_valid), .sts_tag(sts_tag), .sts_err(sts_err),
    .stored_dwords(stored_dwords));

  tx_cmd_parser_properties tx_cmd_parser_properties_i (.clk(clk), .rstn(rstn),
    .wr_valid(link_if.wr_valid), .wr_ready(link_if.wr_ready), .wr_data(link_if.wr_data),
    .pay_valid(pay_valid), .pay_ready(pay_ready), .pay_data(pay_data),
    .buffer_loaded_flag(buffer_loaded_flag), .transmit_error_flag(transmit_error_flag),
    .err_clear(err_clear), .sts_valid(sts_valid), .sts_tag(sts_tag));

  always #25 clk = ~clk;

  // Long receiver stalls so the two-entry buffer fills and the link backs up
  always @(posedge clk)
  begin
    if (pay_valid === 1'b1 && pay_ready) got_q.push_back({pay_last, pay_be, pay_data});
    if (buffer_loaded_flag === 1'b1) n_ioc++;
    if (sts_valid === 1'b1) n_sts++;
    cyc++;
    #1 pay_ready = (cyc % 16) < 9;
  end

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [36:0] got, input logic [36:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle clear pulse, then the sticky flag must read low
  task automatic clear_err();
    err_clear = 1'b1;
    @(posedge clk);
    #1;
    err_clear = 1'b0;
    @(posedge clk);
    #1;
    chk(37'(transmit_error_flag), 37'h0);
  endtask

  task automatic wait_for(input int s);
    int t;
    t = 0;
    do
    begin
      @(posedge clk);
      t++;
    end
    while ((s == 0 ? req_ready : s == 1 ? data_ready : buf_sent) !== 1'b1 && t < 500);
    if (t >= 500)
    begin
      n_errors++;
      tally_and_finish();
    end
    #1;
  endtask

  // Words before the start offset and past the size are expected to vanish
  task automatic send_buf(input logic [31:0] a, input logic [31:0] b);
    int off;
    int e;
    int dw;
    logic [3:0] be;
    off = int'(a[20:16]);
    e = off + int'(a[10:0]);
    dw = (e + 3) / 4;
    k++;
    req_valid = 1'b1;
    cmd_a = a;
    cmd_b = b;
    wait_for(0);
    req_valid = 1'b0;
    data_valid = 1'b1;
    for (int i = 0; i < dw; i++)
    begin
      data = {8'ha5, 8'(k), 16'(i)};
      be = (i == off / 4) ? 4'hf << off % 4 : 4'hf;
      if (i == dw - 1 && e % 4 != 0) be = be & (4'hf >> (4 - e % 4));
      if (i >= off / 4) exp_q.push_back({a[12] && i == dw - 1, be, data});
      wait_for(1);
    end
    data_valid = 1'b0;
    wait_for(2);
  endtask

  task automatic end_pkt(input logic [15:0] tag, input logic err, input logic [9:0] st);
    int t;
    t = 0;
    while (got_q.size() < exp_q.size() && t < 500)
    begin
      @(posedge clk);
      t++;
    end
    if (t >= 500)
    begin
      n_errors++;
      tally_and_finish();
    end
    repeat (4) @(posedge clk);
    #1;
    chk(37'(got_q.size()), 37'(exp_q.size()));
    while (exp_q.size() > 0 && got_q.size() > 0) chk(got_q.pop_front(), exp_q.pop_front());
    chk(37'(sts_tag), 37'(tag));
    chk(37'(sts_err), 37'(err));
    chk(37'(transmit_error_flag), 37'(err));
    chk(37'(stored_dwords), 37'(st));
    exp_q.delete();
    got_q.delete();
  endtask

  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    req_valid = 1'b0;
    cmd_a = 32'h0;
    cmd_b = 32'h0;
    data_valid = 1'b0;
    data = 32'h0;
    err_clear = 1'b0;
    repeat (12) @(posedge clk);
    #1;
    rstn = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    send_buf(32'h8000_3008, 32'h1234_0008);
    end_pkt(16'h1234, 1'b0, 10'h002);
    // Two segments: offsets, 16 and 32 byte end padding, reserved bits set
    send_buf(32'h7d05_e80a, 32'hbeef_0011);
    send_buf(32'h8203_1007, 32'hbeef_0011);
    end_pkt(16'hbeef, 1'b0, 10'h006);
    send_buf(32'h0000_2004, 32'h0001_0008);
    send_buf(32'h0000_1004, 32'h0002_0008);
    end_pkt(16'h0002, 1'b1, 10'h002);
    clear_err();
    send_buf(32'h0000_300c, 32'h0003_000d);
    end_pkt(16'h0003, 1'b1, 10'h003);
    clear_err();
    // Continuation with no packet open, alignment code 3 acting as 4-byte
    send_buf(32'h0300_1004, 32'h0004_0004);
    end_pkt(16'h0004, 1'b1, 10'h004);
    clear_err();
    // First segment while a packet is still open
    send_buf(32'h0000_2004, 32'h0005_0004);
    send_buf(32'h0000_3004, 32'h0005_0004);
    end_pkt(16'h0005, 1'b1, 10'h001);
    chk(37'(n_ioc), 37'h2);
    chk(37'(n_sts), 37'h6);
    tally_and_finish();
  end
endmodule // tx_cmd_parser_tb
